// ===== hw/tpp_pkg.sv
// Package: register map, field layout, timing constants and bus carriers of the timer-paced pattern output
package tpp_pkg;

   // Bus geometry
   localparam int ADDR_W = 24;
   localparam int DATA_W = 32;

   // Register byte addresses
   localparam logic [ADDR_W-1:0] TIMER_START_ADDR   = 24'hFFFFBC;
   localparam logic [ADDR_W-1:0] COUNT_CTRL_ADDR    = 24'hFFFFC0;
   localparam logic [ADDR_W-1:0] MATCH_STATUS_ADDR  = 24'hFFFFC4;
   localparam logic [ADDR_W-1:0] GENERAL_A_ADDR     = 24'hFFFFC8;
   localparam logic [ADDR_W-1:0] CHANNEL_COUNT_ADDR = 24'hFFFFCC;
   localparam logic [ADDR_W-1:0] OUT_ENABLE_ADDR    = 24'hFFFFD0;
   localparam logic [ADDR_W-1:0] OUT_HOLD_ADDR      = 24'hFFFFD4;
   localparam logic [ADDR_W-1:0] NEXT_DATA_ADDR     = 24'hFFFFD8;
   localparam logic [ADDR_W-1:0] TRIG_SEL_ADDR      = 24'hFFFFDC;
   localparam logic [ADDR_W-1:0] MODULE_STOP_ADDR   = 24'hFFFFE0;
   localparam logic [ADDR_W-1:0] PATTERN_STAT_ADDR  = 24'hFFFFE4;

   // Field positions
   localparam int RUN_BIT  = 0;
   localparam int COUNT_CLEAR_SELECT_LSB = 5;
   localparam int FLAG_BIT = 0;
   localparam int STOP_BIT = 15;
   localparam int STALE_BIT = 16;
   localparam int PASS_LSB = 8;

   // Encodings
   localparam logic [2:0] CLR_ON_A = 3'h1;
   localparam logic [1:0] TRIG_CH0 = 2'h0;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // Timing: match interval as printed, cycle count derived from the clock period
   localparam int CLK_PERIOD_NS    = 50;
   localparam int MATCH_PERIOD_NS  = 20000;
   localparam int MATCH_PERIOD_CYC = MATCH_PERIOD_NS / CLK_PERIOD_NS;

   // Reset values
   localparam logic [15:0] GENERAL_A_RST = 16'(MATCH_PERIOD_CYC - 1);
   localparam logic [2:0]  COUNT_CLEAR_SELECT_RST      = CLR_ON_A;

   // Output groups and pattern stream
   localparam int GROUP_W     = 4;
   localparam int GROUPS      = 1;
   localparam int PINS        = GROUP_W * GROUPS;
   localparam int FIFO_W      = 8;
   localparam int FIFO_DEPTH  = 16;
   localparam int PATTERN_LEN = 16;

   // AXI4-Lite carriers
   typedef struct packed {
      logic              awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic              wvalid;
      logic [DATA_W-1:0] wdata;
      logic [3:0]        wstrb;
      logic              bready;
      logic              arvalid;
      logic [ADDR_W-1:0] araddr;
      logic              rready;
   } tpp_axi_req_s;

   typedef struct packed {
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0]        rresp;
   } tpp_axi_rsp_s;

endpackage : tpp_pkg

// ===== hw/tpp_pattern_output.sv
// Timer-paced pattern output: channel 0 timer, one output group, pattern FIFO and AXI4-Lite registers
// Overview of operation
// - Output logic is built as 4-bit groups that share one trigger path.
// - A pin carries pattern data only while its enable bit is 1.
// - Before the first update, pins show the value written to the hold register.
// - On the selected compare match, next data copies into the hold register.
// - Group 0 drives the four pulse pins 0 to 3.
// - Direct output mode: every trigger moves next data straight to the pins.
// - The trigger for the group is the channel 0 compare match.
// - Channel 0 matches every 20 us by default.
// - Each channel 0 compare match also raises a DMA transfer request.
// - After 16 bytes the table restarts and is shown a second time.
// - Writing 1 to run bit 0 makes the channel 0 counter count.
// - Clearing run bit 0 halts the channel 0 counter.
// - Clear select 001 returns the counter to zero on match A.
// - Match flag A clears only by writing 0 after reading it as 1.
// - The stop bit freezes the pattern generator; clearing it resumes.
//
// Added by the designer: register access over AXI4-Lite.

module tpp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW:0]      wrPtr;
   logic [PW:0]      rdPtr;

   // Full when pointers differ only in the wrap bit
   assign inReady  = !((wrPtr[PW] != rdPtr[PW]) && (wrPtr[PW-1:0] == rdPtr[PW-1:0]));
   assign outValid = (wrPtr != rdPtr);
   assign outData  = mem[rdPtr[PW-1:0]];

   // Storage written only on an accepted push
   always_ff @(posedge clk)
   begin
      if (inValid && inReady)
      begin
         mem[wrPtr[PW-1:0]] <= inData;
      end
   end

   // Pointers
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         wrPtr <= '0;
         rdPtr <= '0;
      end
      else
      begin
         if (inValid && inReady)
            wrPtr <= wrPtr + 1'b1;
         if (outValid && outReady)
            rdPtr <= rdPtr + 1'b1;
      end
   end
endmodule : tpp_fifo

module tpp_pattern_output
   import tpp_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire tpp_axi_req_s axiReq,
   output tpp_axi_rsp_s      axiRsp,
   input  wire logic [7:0]   dmaData,
   input  wire logic         dmaValid,
   output logic              dmaReady,
   output logic              dmaReq,
   output logic [PINS-1:0]   pulseOut,
   output logic [PINS-1:0]   pulseOe
);
   logic              awHeld;
   logic              wHeld;
   logic [ADDR_W-1:0] awAddr;
   logic [DATA_W-1:0] wData;
   logic [3:0]        wStrb;
   logic              doWrite;
   logic              wrLo;
   logic              wrHi;
   logic              bValid;
   logic [1:0]        bResp;
   logic              rValid;
   logic [DATA_W-1:0] rData;
   logic [1:0]        rResp;
   logic [DATA_W-1:0] rdValue;
   logic              rdHit;
   logic              arTake;
   logic              channel0Run;
   logic [2:0]        countClearSelect;
   logic              matchFlagA;
   logic              flagArmed;
   logic [15:0]       generalRegA;
   logic [15:0]       channel0Count;
   logic [PINS-1:0]   nextOutputEnable;
   logic [PINS-1:0]   outputDataHold;
   logic [7:0]        nextOutputData;
   logic [1:0]        outputTriggerSelect;
   logic              pulseGenStop;
   logic              ndrStale;
   logic [3:0]        tableIndex;
   logic [3:0]        passCount;
   logic              matchEvt;
   logic              trigger;
   logic              swCountWr;
   logic              holdWr;
   logic              fifoValid;
   logic [7:0]        fifoData;
   logic              fifoPop;

   function automatic logic isMapped(input logic [ADDR_W-1:0] a);
      return (a == TIMER_START_ADDR) || (a == COUNT_CTRL_ADDR) || (a == MATCH_STATUS_ADDR) ||
             (a == GENERAL_A_ADDR) || (a == CHANNEL_COUNT_ADDR) || (a == OUT_ENABLE_ADDR) ||
             (a == OUT_HOLD_ADDR) || (a == NEXT_DATA_ADDR) || (a == TRIG_SEL_ADDR) ||
             (a == MODULE_STOP_ADDR) || (a == PATTERN_STAT_ADDR);
   endfunction : isMapped

   // Bus handshake outputs; a channel is refused only while its previous item is held
   assign axiRsp.awready = !awHeld;
   assign axiRsp.wready  = !wHeld;
   assign axiRsp.bvalid  = bValid;
   assign axiRsp.bresp   = bResp;
   assign axiRsp.arready = !rValid;
   assign axiRsp.rvalid  = rValid;
   assign axiRsp.rdata   = rData;
   assign axiRsp.rresp   = rResp;
   assign arTake  = axiReq.arvalid && !rValid;
   assign doWrite = awHeld && wHeld && !bValid;
   assign wrLo    = doWrite && wStrb[0];
   assign wrHi    = doWrite && wStrb[1];

   // Write channel: address and data taken in either order, one response after both
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         awHeld <= 1'b0;
         wHeld  <= 1'b0;
         awAddr <= '0;
         wData  <= '0;
         wStrb  <= '0;
         bValid <= 1'b0;
         bResp  <= RESP_OKAY;
      end
      else
      begin
         if (axiReq.awvalid && !awHeld)
         begin
            awHeld <= 1'b1;
            awAddr <= axiReq.awaddr;
         end
         if (axiReq.wvalid && !wHeld)
         begin
            wHeld <= 1'b1;
            wData <= axiReq.wdata;
            wStrb <= axiReq.wstrb;
         end
         if (doWrite)
         begin
            awHeld <= 1'b0;
            wHeld  <= 1'b0;
            bValid <= 1'b1;
            bResp  <= isMapped(awAddr) ? RESP_OKAY : RESP_DECERR;
         end
         else if (bValid && axiReq.bready)
            bValid <= 1'b0;
      end
   end

   // Read mux; reserved bits read as zero
   always_comb
   begin
      rdValue = '0;
      rdHit   = 1'b1;
      case (axiReq.araddr)
         TIMER_START_ADDR:   rdValue[RUN_BIT] = channel0Run;
         COUNT_CTRL_ADDR:    rdValue[COUNT_CLEAR_SELECT_LSB +: 3] = countClearSelect;
         MATCH_STATUS_ADDR:  rdValue[FLAG_BIT] = matchFlagA;
         GENERAL_A_ADDR:     rdValue[15:0] = generalRegA;
         CHANNEL_COUNT_ADDR: rdValue[15:0] = channel0Count;
         OUT_ENABLE_ADDR:    rdValue[PINS-1:0] = nextOutputEnable;
         OUT_HOLD_ADDR:      rdValue[PINS-1:0] = outputDataHold;
         NEXT_DATA_ADDR:     rdValue[7:0] = nextOutputData;
         TRIG_SEL_ADDR:      rdValue[1:0] = outputTriggerSelect;
         MODULE_STOP_ADDR:   rdValue[STOP_BIT] = pulseGenStop;
         PATTERN_STAT_ADDR:  rdValue = {15'h0000, ndrStale, 4'h0, passCount, 4'h0, tableIndex};
         default:            rdHit = 1'b0;
      endcase
   end

   // Read channel: answer one cycle after the address is taken
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         rValid <= 1'b0;
         rData  <= '0;
         rResp  <= RESP_OKAY;
      end
      else if (arTake)
      begin
         rValid <= 1'b1;
         rData  <= rdValue;
         rResp  <= rdHit ? RESP_OKAY : RESP_DECERR;
      end
      else if (rValid && axiReq.rready)
         rValid <= 1'b0;
   end

   // Timer control registers
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         channel0Run         <= 1'b0;
         countClearSelect    <= COUNT_CLEAR_SELECT_RST;
         generalRegA         <= GENERAL_A_RST;
         outputTriggerSelect <= TRIG_CH0;
         pulseGenStop        <= 1'b0;
      end
      else
      begin
         if (wrLo && awAddr == TIMER_START_ADDR)
            channel0Run <= wData[RUN_BIT];
         if (wrLo && awAddr == COUNT_CTRL_ADDR)
            countClearSelect <= wData[COUNT_CLEAR_SELECT_LSB +: 3];
         if (wrLo && awAddr == GENERAL_A_ADDR)
            generalRegA[7:0] <= wData[7:0];
         if (wrHi && awAddr == GENERAL_A_ADDR)
            generalRegA[15:8] <= wData[15:8];
         if (wrLo && awAddr == TRIG_SEL_ADDR)
            outputTriggerSelect <= wData[1:0];
         if (wrHi && awAddr == MODULE_STOP_ADDR)
            pulseGenStop <= wData[STOP_BIT];
      end
   end

   // Compare match on A; only a running counter can match
   assign matchEvt  = channel0Run && (channel0Count == generalRegA);
   assign swCountWr = (wrLo || wrHi) && awAddr == CHANNEL_COUNT_ADDR;

   // Channel 0 counter at the full clock rate; a software write takes precedence
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         channel0Count <= '0;
      else if (swCountWr)
      begin
         if (wStrb[0])
            channel0Count[7:0] <= wData[7:0];
         if (wStrb[1])
            channel0Count[15:8] <= wData[15:8];
      end
      else if (channel0Run)
      begin
         if (matchEvt && countClearSelect == CLR_ON_A)
            channel0Count <= '0;
         else
            channel0Count <= channel0Count + 16'h0001;
      end
   end

   // Match flag A: set wins over clear; clear needs a prior read of 1
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         matchFlagA <= 1'b0;
         flagArmed  <= 1'b0;
      end
      else
      begin
         if (matchEvt)
            matchFlagA <= 1'b1;
         else if (wrLo && awAddr == MATCH_STATUS_ADDR && flagArmed && !wData[FLAG_BIT])
            matchFlagA <= 1'b0;
         if (arTake && axiReq.araddr == MATCH_STATUS_ADDR && matchFlagA)
            flagArmed <= 1'b1;
         else if (wrLo && awAddr == MATCH_STATUS_ADDR)
            flagArmed <= 1'b0;
      end
   end

   // DMA request pulse, one cycle per compare match
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         dmaReq <= 1'b0;
      else
         dmaReq <= matchEvt;
   end

   // Pattern bytes queue here; the DMA stalls on dmaReady when the pins fall behind
   tpp_fifo #(
      .WIDTH (FIFO_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk      (clk),
      .rst_n    (rst_n),
      .inValid  (dmaValid),
      .inReady  (dmaReady),
      .inData   (dmaData),
      .outValid (fifoValid),
      .outReady (fifoPop),
      .outData  (fifoData)
   );

   // Update trigger: channel 0 match, generator not stopped
   assign trigger = matchEvt && outputTriggerSelect == TRIG_CH0 && !pulseGenStop;
   assign fifoPop = ndrStale && fifoValid && !pulseGenStop && !trigger;
   assign holdWr  = wrLo && awAddr == OUT_HOLD_ADDR;

   // Next data: refilled from the queue once the previous byte went out
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         nextOutputData   <= '0;
         ndrStale         <= 1'b1;
         nextOutputEnable <= '0;
      end
      else
      begin
         if (wrLo && awAddr == OUT_ENABLE_ADDR)
            nextOutputEnable <= wData[PINS-1:0];
         if (trigger)
            ndrStale <= 1'b1;
         else if (fifoPop)
         begin
            nextOutputData <= fifoData;
            ndrStale       <= 1'b0;
         end
         else if (wrLo && awAddr == NEXT_DATA_ADDR)
         begin
            nextOutputData <= wData[7:0];
            ndrStale       <= 1'b0;
         end
      end
   end

   // Table position one past the byte on the pins; a wrap starts the next pass
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         tableIndex <= '0;
         passCount  <= '0;
      end
      else if (trigger)
      begin
         tableIndex <= tableIndex + 4'h1;
         if (tableIndex == 4'(PATTERN_LEN - 1))
            passCount <= passCount + 4'h1;
      end
   end

   // Per-group hold register in direct mode; on a trigger only enabled bits take new data
   for (genvar g = 0; g < GROUPS; g++)
   begin : g_group
      localparam int LO = g * GROUP_W;
      always_ff @(posedge clk)
      begin
         if (!rst_n)
            outputDataHold[LO +: GROUP_W] <= '0;
         else if (trigger)
            outputDataHold[LO +: GROUP_W] <= (nextOutputData[LO +: GROUP_W] & nextOutputEnable[LO +: GROUP_W]) |
                                             (outputDataHold[LO +: GROUP_W] & ~nextOutputEnable[LO +: GROUP_W]);
         else if (holdWr)
            outputDataHold[LO +: GROUP_W] <= wData[LO +: GROUP_W];
      end
   end

   // Pins driven only where enabled
   assign pulseOut = outputDataHold & nextOutputEnable;
   assign pulseOe  = nextOutputEnable;

   property p_pin_gate;
      @(posedge clk) disable iff (!rst_n)
      (pulseOe == nextOutputEnable) && ((pulseOut & ~pulseOe) == '0) && ((pulseOut ^ outputDataHold) & pulseOe) == '0;
   endproperty
   a_pin_gate: assert property (p_pin_gate) else $error("pin not gated by enable");

   property p_update;
      @(posedge clk) disable iff (!rst_n)
      trigger && nextOutputEnable == '1 |=> outputDataHold == $past(nextOutputData[PINS-1:0]);
   endproperty
   a_update: assert property (p_update) else $error("hold not updated on match");

   property p_dma_req;
      @(posedge clk) disable iff (!rst_n)
      matchEvt |=> dmaReq ##1 (!dmaReq || $past(matchEvt));
   endproperty
   a_dma_req: assert property (p_dma_req) else $error("dma request not one pulse per match");

   property p_count_run;
      @(posedge clk) disable iff (!rst_n)
      channel0Run && !matchEvt && !swCountWr |=> channel0Count == $past(channel0Count) + 16'h0001;
   endproperty
   a_count_run: assert property (p_count_run) else $error("counter did not advance");

   property p_count_halt;
      @(posedge clk) disable iff (!rst_n)
      !channel0Run && !swCountWr |=> $stable(channel0Count) && (!matchFlagA || $past(matchFlagA));
   endproperty
   a_count_halt: assert property (p_count_halt) else $error("halted counter moved");

   property p_clear_a;
      @(posedge clk) disable iff (!rst_n)
      matchEvt && countClearSelect == CLR_ON_A && !swCountWr |=> channel0Count == 16'h0000 ##1 !matchEvt || generalRegA == 16'h0000;
   endproperty
   a_clear_a: assert property (p_clear_a) else $error("counter not cleared on match A");

   property p_flag_hold;
      @(posedge clk) disable iff (!rst_n)
      matchFlagA && !flagArmed |=> matchFlagA;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag cleared without prior read");

   property p_stop;
      @(posedge clk) disable iff (!rst_n)
      pulseGenStop && !holdWr |=> $stable(outputDataHold) && $stable(tableIndex);
   endproperty
   a_stop: assert property (p_stop) else $error("stopped generator changed output");

endmodule : tpp_pattern_output

// ===== verif/tpp_pin_load.sv
// External load model on the four pulse pins
module tpp_pin_load
   import tpp_pkg::*;
(
   input  wire logic            clk,
   input  wire logic [PINS-1:0] pulseOut,
   input  wire logic [PINS-1:0] pulseOe,
   output logic      [PINS-1:0] pinLevel
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [PINS-1:0] last = '0;

   // Remember the level seen, so a released pin can float away from it
   always @(posedge clk)
      last <= pinLevel;

   // Undriven pins show the inverse of the last level, never a stale copy
   assign pinLevel = (pulseOut & pulseOe) | (~last & ~pulseOe);
endmodule : tpp_pin_load

// ===== verif/tb_top.sv
// Self-checking bench of the timer-paced pattern output
module tb_top
   import tpp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic            clk = 1'b0;
   logic            rst_n = 1'b0;
   tpp_axi_req_s    req = '0;
   tpp_axi_rsp_s    rsp;
   logic [7:0]      dmaData = 8'h00;
   logic            dmaValid = 1'b0;
   logic            dmaReady;
   logic            dmaReq;
   logic [PINS-1:0] pulseOut;
   logic [PINS-1:0] pulseOe;
   logic [PINS-1:0] pinLevel;
   int              errors = 0;
   int              comparisons = 0;
   int              cyc = 0;
   int              lastMatch = 0;
   int              matchCount = 0;
   int              sent = 0;
   int              k;
   bit              patternOn = 0;
   bit              dTaken;
   logic [7:0]      q[$];
   logic [31:0]     rd;
   logic [31:0]     c1;
   logic [1:0]      resp;
   logic [3:0]      h;
   logic [3:0]      e;

   tpp_pattern_output uut (.clk(clk), .rst_n(rst_n), .axiReq(req), .axiRsp(rsp), .dmaData(dmaData),
      .dmaValid(dmaValid), .dmaReady(dmaReady), .dmaReq(dmaReq), .pulseOut(pulseOut), .pulseOe(pulseOe));
   tpp_pin_load load (.clk(clk), .pulseOut(pulseOut), .pulseOe(pulseOe), .pinLevel(pinLevel));

   // 20 MHz clock and a cycle count for period checks
   always #25 clk = ~clk;
   always @(posedge clk)
      cyc <= cyc + 1;

   // Table entry: both nibbles equal the index, wrapping every 16
   function automatic logic [7:0] tableByte(input int i);
      return {2{4'(i)}};
   endfunction : tableByte

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : check

   // One AXI4-Lite transfer; handshakes are judged at the negedge, acted on after the posedge
   task automatic axi(input bit wr, input logic [23:0] a, input logic [31:0] d, output logic [31:0] data,
      output logic [1:0] r);
      int n;
      bit done;
      bit awGo;
      bit wGo;
      bit arGo;
      n = 0;
      done = 0;
      // Start on a fresh rising edge, so a release from the previous call is never overwritten in one step
      @(posedge clk);
      if (wr)
      begin
         req.awaddr <= a;
         req.wdata <= d;
         req.wstrb <= 4'hF;
         req.awvalid <= 1'b1;
         req.wvalid <= 1'b1;
         req.bready <= 1'b1;
      end
      else
      begin
         req.araddr <= a;
         req.arvalid <= 1'b1;
         req.rready <= 1'b1;
      end
      while (!done && n < 200)
      begin
         @(negedge clk);
         n++;
         awGo = req.awvalid && rsp.awready;
         wGo = req.wvalid && rsp.wready;
         arGo = req.arvalid && rsp.arready;
         done = wr ? (rsp.bvalid === 1'b1) : (rsp.rvalid === 1'b1);
         data = rsp.rdata;
         r = wr ? rsp.bresp : rsp.rresp;
         @(posedge clk);
         if (awGo)
            req.awvalid <= 1'b0;
         if (wGo)
            req.wvalid <= 1'b0;
         if (arGo)
            req.arvalid <= 1'b0;
         if (done)
         begin
            req.bready <= 1'b0;
            req.rready <= 1'b0;
         end
      end
      if (!done)
      begin
         errors++;
         $display("bus transfer hung at %0t", $time);
      end
   endtask : axi

   task automatic wrReg(input logic [23:0] a, input logic [31:0] d);
      axi(1'b1, a, d, rd, resp);
   endtask : wrReg

   task automatic rdChk(input logic [23:0] a, input logic [31:0] exp);
      axi(1'b0, a, 32'h0, rd, resp);
      check(rd, exp);
      check(32'(resp), 32'(RESP_OKAY));
   endtask : rdChk

   task automatic waitMatches(input int target);
      int n;
      n = 0;
      while (matchCount < target && n < 30000)
      begin
         @(posedge clk);
         n++;
      end
      // A timer that never matches must not slip through to the verdict
      if (matchCount < target)
      begin
         errors++;
         $display("match wait timed out at %0t", $time);
      end
   endtask : waitMatches

   task finish_test;
      $display("comparisons %0d, mismatches %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finish_test

   // DMA stand-in: one table byte per request, two passes, then silence so a stale value shows
   initial forever
   begin
      @(negedge clk);
      dTaken = dmaValid && dmaReady;
      if (dmaReq === 1'b1)
      begin
         matchCount++;
         if (patternOn)
         begin
            check(32'(pulseOut), 32'((matchCount <= 2 * PATTERN_LEN) ? 4'(matchCount - 1) : 4'hF));
            if (matchCount > 1)
               check(32'(cyc - lastMatch), 32'(MATCH_PERIOD_CYC));
         end
         lastMatch = cyc;
         if (patternOn && sent < 2 * PATTERN_LEN)
         begin
            q.push_back(tableByte(sent));
            sent++;
         end
      end
      @(posedge clk);
      if (dTaken)
         void'(q.pop_front());
      dmaValid <= (q.size() > 0);
      // Data off the bus is scrambled rather than held, so nothing leans on a stale byte
      dmaData <= (q.size() > 0) ? q[0] : ~dmaData;
   end

   // Watchdog sized well beyond some 15400 expected cycles
   initial
   begin
      #(50 * 60000);
      errors++;
      $display("watchdog expired at %0t", $time);
      finish_test();
   end

   initial
   begin
      void'($urandom(32'hC079A0DA));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rdChk(TIMER_START_ADDR, 32'h0);
      rdChk(COUNT_CTRL_ADDR, 32'(CLR_ON_A) << COUNT_CLEAR_SELECT_LSB);
      rdChk(GENERAL_A_ADDR, 32'(MATCH_PERIOD_CYC - 1));
      rdChk(OUT_ENABLE_ADDR, 32'h0);
      axi(1'b0, 24'hFFFFF0, 32'h0, rd, resp);
      check(rd, 32'h0);
      check(32'(resp), 32'(RESP_DECERR));
      axi(1'b1, 24'hFFFFF0, 32'hFFFFFFFF, rd, resp);
      check(32'(resp), 32'(RESP_DECERR));
      // Random hold and enable pairs before any trigger
      repeat (8)
      begin
         h = 4'($urandom);
         e = 4'($urandom);
         wrReg(OUT_ENABLE_ADDR, 32'(e));
         wrReg(OUT_HOLD_ADDR, 32'(h));
         @(negedge clk);
         check(32'(pulseOut), 32'(h & e));
         check(32'(pulseOe), 32'(e));
         check(32'(pinLevel & pulseOe), 32'(h & e));
      end
      // Two passes of the table, then one stale update
      wrReg(OUT_ENABLE_ADDR, 32'hF);
      wrReg(TRIG_SEL_ADDR, 32'(TRIG_CH0));
      q.push_back(tableByte(0));
      sent = 1;
      patternOn = 1;
      wrReg(TIMER_START_ADDR, 32'h1 << RUN_BIT);
      waitMatches(2 * PATTERN_LEN + 1);
      patternOn = 0;
      // 33 updates: index wrapped twice to 1, and the last byte went out stale
      rdChk(PATTERN_STAT_ADDR, (32'h1 << STALE_BIT) | (32'h2 << PASS_LSB) | 32'h1);
      // Stopped generator keeps its pins while a byte waits in the FIFO
      wrReg(MODULE_STOP_ADDR, 32'h1 << STOP_BIT);
      // One byte more than the queue holds, so back-pressure must show while draining is frozen
      repeat (FIFO_DEPTH + 1) q.push_back(8'h55);
      k = matchCount;
      waitMatches(k + 1);
      @(negedge clk);
      check(32'(pulseOut), 32'hF);
      check(32'(dmaReady), 32'h0);
      wrReg(MODULE_STOP_ADDR, 32'h0);
      waitMatches(matchCount + 2);
      @(negedge clk);
      check(32'(pulseOut), 32'h5);
      // Halted counter: no matches and a frozen count
      wrReg(TIMER_START_ADDR, 32'h0);
      k = matchCount;
      axi(1'b0, CHANNEL_COUNT_ADDR, 32'h0, c1, resp);
      repeat (800) @(posedge clk);
      rdChk(CHANNEL_COUNT_ADDR, c1);
      check(32'(matchCount), 32'(k));
      // Flag clears only after it was read as one
      wrReg(MATCH_STATUS_ADDR, 32'h0);
      rdChk(MATCH_STATUS_ADDR, 32'h1 << FLAG_BIT);
      wrReg(MATCH_STATUS_ADDR, 32'h0);
      rdChk(MATCH_STATUS_ADDR, 32'h0);
      finish_test();
   end
endmodule : tb_top
